//--- inc/pwb_pkg.sv
// constants, opcode set and decode helpers for the programmed word/byte i/o executor
package pwb_pkg;

	// widths of the data path and the i/o address
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;
	localparam int ADDR_W = 8;
	localparam int DEV_W = 5;
	localparam int FUNC_W = 3;
	localparam int OP_W = 5;

	// field positions inside the eight-bit i/o address
	localparam int FUNC_LSB = 0;
	localparam int DEV_LSB = FUNC_W;

	// i/o opcodes handled here; code zero means no operation
	typedef enum logic [OP_W-1:0] {
		op_none,
		op_word_in_to_acc,
		op_word_in_and_acc,
		op_word_in_to_index,
		op_word_in_and_index,
		op_word_out_from_acc,
		op_word_out_from_index,
		op_word_out_zero,
		op_cond_word_read_acc,
		op_cond_word_read_and_acc,
		op_cond_word_read_index,
		op_cond_word_read_and_index,
		op_cond_word_write_acc,
		op_cond_word_write_index,
		op_cond_word_write_zero,
		op_byte_in_to_acc,
		op_byte_in_and_acc,
		op_byte_in_to_index,
		op_byte_in_and_index,
		op_cond_byte_read_acc,
		op_cond_byte_read_and_acc,
		op_cond_byte_read_index,
		op_cond_byte_read_and_index
	} pwb_op_t;

	// decoded properties of one opcode
	typedef struct packed {
		logic valid;
		logic cond;
		logic input_op;
		logic index;
		logic byte_op;
		logic mask;
		logic zero;
	} pwb_cls_t;

	// executor states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SENSE,
		ST_XFER
	} pwb_state_t;

	// opcode to class: valid, cond, input, index, byte, mask, zero
	function automatic pwb_cls_t op_class(input logic [OP_W-1:0] code);
		pwb_cls_t c;
		c = '0;
		case (pwb_op_t'(code))
			op_word_in_to_acc: c = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0};
			op_word_in_and_acc: c = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0};
			op_word_in_to_index: c = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0};
			op_word_in_and_index: c = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0};
			op_word_out_from_acc: c = '{1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0};
			op_word_out_from_index: c = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0};
			op_word_out_zero: c = '{1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1};
			op_cond_word_read_acc: c = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0};
			op_cond_word_read_and_acc: c = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0};
			op_cond_word_read_index: c = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0};
			op_cond_word_read_and_index: c = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0};
			op_cond_word_write_acc: c = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0};
			op_cond_word_write_index: c = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0};
			op_cond_word_write_zero: c = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1};
			op_byte_in_to_acc: c = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0};
			op_byte_in_and_acc: c = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0};
			op_byte_in_to_index: c = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0};
			op_byte_in_and_index: c = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0};
			op_cond_byte_read_acc: c = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0};
			op_cond_byte_read_and_acc: c = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0};
			op_cond_byte_read_index: c = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0};
			op_cond_byte_read_and_index: c = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0};
			default: c = '0;
		endcase
		return c;
	endfunction

endpackage

//--- core/pwb_merge.sv
// input data merge: word load, masked load, byte load into the target register
`timescale 1ns/1ps
module pwb_merge #(
	parameter int DATA_W = pwb_pkg::DATA_W,
	parameter int BYTE_W = pwb_pkg::BYTE_W
) (
	// current target register and bus word
	input wire logic [DATA_W-1:0] reg_val,
	input wire logic [DATA_W-1:0] in_data,
	// transfer kind
	input wire logic narrow,
	input wire logic byte_op,
	input wire logic mask,
	// value to write back
	output logic [DATA_W-1:0] result
);

	logic [DATA_W-1:0] word_raw;
	logic [BYTE_W-1:0] byte_raw;

	// narrow device fills the upper byte with zeros
	assign word_raw = narrow ? {{(DATA_W-BYTE_W){1'h0}}, in_data[BYTE_W-1:0]} : in_data; // RQ6
	// low byte, optionally anded with the old low byte
	assign byte_raw = mask ? (in_data[BYTE_W-1:0] & reg_val[BYTE_W-1:0]) :
		in_data[BYTE_W-1:0]; // RQ18 RQ20

	// byte forms keep the high byte, word forms replace or and the whole word
	always_comb begin
		if (byte_op) begin
			result = {reg_val[DATA_W-1:BYTE_W], byte_raw}; // RQ16 RQ17 RQ19
		end else if (mask) begin
			result = word_raw & reg_val; // RQ9 RQ13
		end else begin
			result = word_raw; // RQ8 RQ12
		end
	end

endmodule

//--- core/pwb_io_exec.sv
// processor-side executor for programmed word and byte i/o instructions
`timescale 1ns/1ps
// Summary of operation
// [RQ1] software inhibits status for one instruction before clearing pending interrupts by select
// [RQ2] interrupt requests are judged before any bus effect of the instruction; executor judges them on a false sense, with select and sense on the bus
// [RQ3] every word instruction moves sixteen bits in one transfer
// [RQ4] conditional forms repeat sensing on false, transfer and advance on true
// [RQ5] interrupt taken on false sense resumes at the same conditional instruction
// [RQ6] word input from an eight-bit device loads zeros in the upper byte
// [RQ7] eight-bit device ignores the upper byte of an output word
// [RQ8] unconditional word input replaces a or x with the bus word
// [RQ9] unconditional masked word input ands bus word into a or x
// [RQ10] unconditional word output drives full a or x contents, no sense test
// [RQ11] output zero sends an all-zero word
// [RQ12] conditional word read replaces a or x once sense is true
// [RQ13] conditional masked word read ands bus word into a or x on true
// [RQ14] conditional word write sends full a or x after true sense
// [RQ15] conditional write zero sends all zeros after true sense
// [RQ16] byte input writes the low byte and keeps the high byte
// [RQ17] unconditional byte input loads the low half without sense test
// [RQ18] unconditional masked byte input ands into the low byte only
// [RQ19] conditional byte read loads the low half on true, keeps upper half
// [RQ20] conditional masked byte read ands into the low byte on true
// [RQ21] eight-bit i/o address splits into five-bit device and three-bit function
// [RQ22] word or byte width follows the opcode only, never the memory mode flag
// [RQ23] peripheral answers sense in the same cycle and drives data while sampled
module pwb_io_exec #(
	parameter int DATA_W = pwb_pkg::DATA_W,
	parameter int ADDR_W = pwb_pkg::ADDR_W,
	parameter int DEV_W = pwb_pkg::DEV_W,
	parameter int FUNC_W = pwb_pkg::FUNC_W,
	parameter int OP_W = pwb_pkg::OP_W
) (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RESET,
	// instruction issue from the sequencer
	input wire logic START,
	input wire logic [OP_W-1:0] OPCODE,
	input wire logic [ADDR_W-1:0] IO_ADDR,
	input wire logic [DATA_W-1:0] ACC_IN,
	input wire logic [DATA_W-1:0] INDEX_IN,
	// interrupt state from the sequencer
	input wire logic IRQ_REQ,
	input wire logic INT_INHIBIT,
	// completion and write back
	output logic BUSY,
	output logic DONE,
	output logic DONE_ADVANCE,
	output logic INT_ACK,
	output logic WB_VALID,
	output logic WB_TO_INDEX,
	output logic [DATA_W-1:0] WB_DATA,
	// peripheral i/o bus
	output logic [DEV_W-1:0] IO_DEV_ADDR,
	output logic [FUNC_W-1:0] IO_FUNC,
	output logic IO_SENSE,
	input wire logic IO_SENSE_RESP,
	output logic IO_IN_STROBE,
	input wire logic [DATA_W-1:0] IO_DATA_IN,
	input wire logic IO_NARROW,
	output logic IO_OUT_STROBE,
	output logic [DATA_W-1:0] IO_DATA_OUT
);

	pwb_pkg::pwb_state_t state_q;
	pwb_pkg::pwb_state_t state_d;
	pwb_pkg::pwb_cls_t cls_q;
	pwb_pkg::pwb_cls_t cls_in;
	logic [ADDR_W-1:0] addr_q;
	logic [DATA_W-1:0] src_q;
	logic [DATA_W-1:0] out_q;
	logic [DATA_W-1:0] wb_q;
	logic [DATA_W-1:0] merged;
	logic done_q;
	logic adv_q;
	logic ack_q;
	logic wbv_q;
	logic take;
	logic int_take;
	logic sense_true;
	logic sense_false;

	// decode of the opcode being issued; width comes from the opcode alone
	assign cls_in = pwb_pkg::op_class(OPCODE); // RQ22
	assign take = START && (state_q == pwb_pkg::ST_IDLE);

	// interrupt judged from the request as seen now, in the sense cycle while select and sense are on the bus, before any transfer
	assign int_take = IRQ_REQ && !INT_INHIBIT; // RQ2 RQ1
	// sense answer is taken in the same cycle as the sense strobe
	assign sense_true = (state_q == pwb_pkg::ST_SENSE) && IO_SENSE_RESP; // RQ23
	assign sense_false = (state_q == pwb_pkg::ST_SENSE) && !IO_SENSE_RESP;

	// next state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			pwb_pkg::ST_IDLE: begin
				if (take && cls_in.valid && cls_in.cond) begin
					state_d = pwb_pkg::ST_SENSE; // RQ4
				end else if (take && cls_in.valid) begin
					state_d = pwb_pkg::ST_XFER; // RQ10 RQ17
				end
			end
			pwb_pkg::ST_SENSE: begin
				if (IO_SENSE_RESP) begin
					state_d = pwb_pkg::ST_XFER; // RQ4
				end else if (int_take) begin
					state_d = pwb_pkg::ST_IDLE; // RQ5
				end else begin
					state_d = pwb_pkg::ST_SENSE; // RQ4
				end
			end
			pwb_pkg::ST_XFER: begin
				state_d = pwb_pkg::ST_IDLE;
			end
			default: begin
				state_d = pwb_pkg::ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			state_q <= pwb_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// instruction latch: class, address and the chosen source register
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			cls_q <= '0;
			addr_q <= '0;
			src_q <= '0;
		end else if (take) begin
			cls_q <= cls_in;
			addr_q <= IO_ADDR;
			src_q <= cls_in.index ? INDEX_IN : ACC_IN;
		end
	end

	// output word is set up at issue, so it is stable through sense and transfer
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			out_q <= '0;
		end else if (take) begin
			if (!cls_in.valid || cls_in.input_op || cls_in.zero) begin
				out_q <= '0; // RQ11 RQ15
			end else begin
				out_q <= cls_in.index ? INDEX_IN : ACC_IN; // RQ3 RQ10 RQ14
			end
		end
	end

	// merge of the bus word into the target register
	pwb_merge #(
		.DATA_W(DATA_W),
		.BYTE_W(pwb_pkg::BYTE_W)
	) u_merge (
		.reg_val(src_q),
		.in_data(IO_DATA_IN),
		.narrow(IO_NARROW),
		.byte_op(cls_q.byte_op),
		.mask(cls_q.mask),
		.result(merged)
	);

	// write-back word captured on the input strobe
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			wb_q <= '0;
			wbv_q <= 1'h0;
		end else begin
			wbv_q <= (state_q == pwb_pkg::ST_XFER) && cls_q.input_op;
			if ((state_q == pwb_pkg::ST_XFER) && cls_q.input_op) begin
				wb_q <= merged; // RQ8 RQ9 RQ12 RQ13 RQ16 RQ19
			end
		end
	end

	// completion: done and ack pulse, advance is held until the next completion; an interrupt on false sense finishes without advancing
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			done_q <= 1'h0;
			adv_q <= 1'h0;
			ack_q <= 1'h0;
		end else begin
			done_q <= (state_q == pwb_pkg::ST_XFER) || (sense_false && int_take) ||
				(take && !cls_in.valid);
			ack_q <= sense_false && int_take; // RQ5
			if ((state_q == pwb_pkg::ST_XFER) || (take && !cls_in.valid)) begin
				adv_q <= 1'h1; // RQ4
			end else if (sense_false && int_take) begin
				adv_q <= 1'h0; // RQ5
			end
		end
	end

	// bus drive: address fields split, strobes from state
	assign IO_DEV_ADDR = addr_q[pwb_pkg::DEV_LSB +: DEV_W]; // RQ21
	assign IO_FUNC = addr_q[pwb_pkg::FUNC_LSB +: FUNC_W]; // RQ21
	assign IO_SENSE = (state_q == pwb_pkg::ST_SENSE); // RQ4
	assign IO_IN_STROBE = (state_q == pwb_pkg::ST_XFER) && cls_q.input_op;
	assign IO_OUT_STROBE = (state_q == pwb_pkg::ST_XFER) && !cls_q.input_op;
	assign IO_DATA_OUT = out_q; // RQ3

	// sequencer side
	assign BUSY = (state_q != pwb_pkg::ST_IDLE);
	assign DONE = done_q;
	assign DONE_ADVANCE = adv_q;
	assign INT_ACK = ack_q;
	assign WB_VALID = wbv_q;
	assign WB_TO_INDEX = cls_q.index;
	assign WB_DATA = wb_q;

	// sense only on conditional forms
	property p_sense_cond;
		@(posedge REF_CLK) disable iff (RESET) IO_SENSE |-> cls_q.cond;
	endproperty
	a_sense_cond: assert property (p_sense_cond) else $error("sense on unconditional op"); // RQ4

	// false answer with no interrupt repeats the sense
	property p_repeat;
		@(posedge REF_CLK) disable iff (RESET) sense_false && !int_take |=> IO_SENSE && !DONE;
	endproperty
	a_repeat: assert property (p_repeat) else $error("false sense did not repeat"); // RQ4

	// true answer gives one transfer then completion with advance
	property p_true_xfer;
		@(posedge REF_CLK) disable iff (RESET)
			sense_true |=> (IO_IN_STROBE || IO_OUT_STROBE) ##1 (DONE && DONE_ADVANCE);
	endproperty
	a_true_xfer: assert property (p_true_xfer) else $error("true sense not transferred"); // RQ4

	// interrupt on false sense: ack, no advance, no write back
	property p_int_resume;
		@(posedge REF_CLK) disable iff (RESET)
			sense_false && int_take |=> INT_ACK && DONE && !DONE_ADVANCE && !WB_VALID && !BUSY;
	endproperty
	a_int_resume: assert property (p_int_resume) else $error("interrupt resume wrong"); // RQ5

	// unconditional forms go straight to the transfer
	property p_uncond;
		@(posedge REF_CLK) disable iff (RESET)
			take && cls_in.valid && !cls_in.cond |=> !IO_SENSE && (IO_IN_STROBE || IO_OUT_STROBE);
	endproperty
	a_uncond: assert property (p_uncond) else $error("unconditional op sensed"); // RQ10

	// byte input keeps the high byte of the source register
	property p_byte_hi;
		@(posedge REF_CLK) disable iff (RESET)
			IO_IN_STROBE && cls_q.byte_op |=>
			WB_DATA[DATA_W-1:pwb_pkg::BYTE_W] == $past(src_q[DATA_W-1:pwb_pkg::BYTE_W]);
	endproperty
	a_byte_hi: assert property (p_byte_hi) else $error("byte input changed high byte"); // RQ16

	// narrow word input gives a zero high byte
	property p_narrow;
		@(posedge REF_CLK) disable iff (RESET)
			IO_IN_STROBE && !cls_q.byte_op && IO_NARROW |=>
			WB_VALID && (WB_DATA[DATA_W-1:pwb_pkg::BYTE_W] == '0);
	endproperty
	a_narrow: assert property (p_narrow) else $error("narrow input high byte not zero"); // RQ6

	// zero forms put zeros on the bus
	property p_zero_out;
		@(posedge REF_CLK) disable iff (RESET) IO_OUT_STROBE && cls_q.zero |-> IO_DATA_OUT == '0;
	endproperty
	a_zero_out: assert property (p_zero_out) else $error("zero output not zero"); // RQ11

	// register output drives the full source word
	property p_reg_out;
		@(posedge REF_CLK) disable iff (RESET) IO_OUT_STROBE && !cls_q.zero |-> IO_DATA_OUT == src_q;
	endproperty
	a_reg_out: assert property (p_reg_out) else $error("output word not source"); // RQ14

	// plain and masked word inputs
	property p_word_in;
		@(posedge REF_CLK) disable iff (RESET)
			IO_IN_STROBE && !cls_q.byte_op && !IO_NARROW |=>
			WB_DATA == (cls_q.mask ? ($past(IO_DATA_IN) & $past(src_q)) : $past(IO_DATA_IN));
	endproperty
	a_word_in: assert property (p_word_in) else $error("word input result wrong"); // RQ9

	// address fields follow the issued address
	property p_addr;
		@(posedge REF_CLK) disable iff (RESET) take |=> {IO_DEV_ADDR, IO_FUNC} == $past(IO_ADDR);
	endproperty
	a_addr: assert property (p_addr) else $error("address split wrong"); // RQ21

	// one data transfer per instruction, never two cycles in a row
	property p_one_xfer;
		@(posedge REF_CLK) disable iff (RESET)
			IO_IN_STROBE || IO_OUT_STROBE |=> !IO_IN_STROBE && !IO_OUT_STROBE;
	endproperty
	a_one_xfer: assert property (p_one_xfer) else $error("two transfers in a row"); // RQ3

	// a false answer moves no data and writes nothing back
	property p_false_no_xfer;
		@(posedge REF_CLK) disable iff (RESET)
			sense_false |=> !IO_IN_STROBE && !IO_OUT_STROBE && !WB_VALID;
	endproperty
	a_false_no_xfer: assert property (p_false_no_xfer) else $error("false sense moved data"); // RQ4

	// an inhibited request is not acknowledged, the sense goes on
	property p_inhibit;
		@(posedge REF_CLK) disable iff (RESET)
			sense_false && INT_INHIBIT |=> !INT_ACK && IO_SENSE;
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("inhibited request taken"); // RQ2

	// a true answer wins over a pending request in the same cycle
	property p_true_wins;
		@(posedge REF_CLK) disable iff (RESET)
			sense_true && int_take |=> BUSY && !INT_ACK;
	endproperty
	a_true_wins: assert property (p_true_wins) else $error("request beat true sense"); // RQ5

	// byte input low byte is the bus byte, anded with the old low byte when masked
	property p_byte_lo;
		@(posedge REF_CLK) disable iff (RESET)
			IO_IN_STROBE && cls_q.byte_op |=> WB_DATA[pwb_pkg::BYTE_W-1:0] ==
			($past(IO_DATA_IN[pwb_pkg::BYTE_W-1:0]) &
			($past(cls_q.mask) ? $past(src_q[pwb_pkg::BYTE_W-1:0]) : '1));
	endproperty
	a_byte_lo: assert property (p_byte_lo) else $error("byte input low byte wrong"); // RQ18

	// narrow plain word input keeps the low byte from the bus
	property p_narrow_lo;
		@(posedge REF_CLK) disable iff (RESET)
			IO_IN_STROBE && !cls_q.byte_op && !cls_q.mask && IO_NARROW |=>
			WB_DATA[pwb_pkg::BYTE_W-1:0] == $past(IO_DATA_IN[pwb_pkg::BYTE_W-1:0]);
	endproperty
	a_narrow_lo: assert property (p_narrow_lo) else $error("narrow input low byte wrong"); // RQ8

	// output word holds still while the sense repeats
	property p_out_hold;
		@(posedge REF_CLK) disable iff (RESET) IO_SENSE |=> $stable(IO_DATA_OUT);
	endproperty
	a_out_hold: assert property (p_out_hold) else $error("output word moved in sense"); // RQ14

	// zero forms load an all-zero output word at issue
	property p_zero_issue;
		@(posedge REF_CLK) disable iff (RESET)
			take && cls_in.zero |=> IO_DATA_OUT == '0;
	endproperty
	a_zero_issue: assert property (p_zero_issue) else $error("zero form word not zero"); // RQ15

	// output forms end without a write back
	property p_out_no_wb;
		@(posedge REF_CLK) disable iff (RESET) IO_OUT_STROBE |=> DONE && !WB_VALID;
	endproperty
	a_out_no_wb: assert property (p_out_no_wb) else $error("output form wrote back"); // RQ10

endmodule

//--- test/pwb_periph_model.sv
// peripheral model on the i/o bus: sense answers, read data, write capture
`timescale 1ns/1ps
module pwb_periph_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// behaviour asked by the bench
	input wire logic [3:0] false_n,
	input wire logic [15:0] rd_word,
	input wire logic narrow,
	// i/o bus
	input wire logic io_sense,
	output logic sense_resp,
	input wire logic in_strobe,
	output logic [15:0] data_in,
	output logic narrow_o,
	input wire logic out_strobe,
	input wire logic [15:0] data_out,
	// activity seen
	output int sense_cnt,
	output int in_cnt,
	output int out_cnt,
	output logic [15:0] last_out,
	output logic [7:0] last_byte
);
	int run_q;
	logic [15:0] prev_q;
	// false for false_n sense cycles, then true within the same cycle
	assign sense_resp = io_sense && (run_q >= false_n);
	// data only while sampled, inverted leftovers otherwise
	assign data_in = in_strobe ? rd_word : ~prev_q;
	assign narrow_o = in_strobe ? narrow : ~narrow;
	// an eight-bit device keeps only the low byte
	assign last_byte = last_out[7:0];
	// activity counters and write capture
	always @(posedge clk) begin
		if (rst) begin
			run_q <= 0;
			prev_q <= 16'h0000;
			sense_cnt <= 0;
			in_cnt <= 0;
			out_cnt <= 0;
			last_out <= 16'h0000;
		end else begin
			run_q <= io_sense ? run_q + 1 : 0;
			if (io_sense) sense_cnt <= sense_cnt + 1;
			if (in_strobe) begin
				in_cnt <= in_cnt + 1;
				prev_q <= rd_word;
			end
			if (out_strobe) begin
				out_cnt <= out_cnt + 1;
				last_out <= data_out;
			end
		end
	end
endmodule

//--- test/pwb_io_exec_tb.sv
// self-checking bench for the programmed word/byte i/o executor
`timescale 1ns/1ps
module pwb_io_exec_tb;
	logic REF_CLK = 1'h0;
	logic RESET = 1'h1;
	logic START = 1'h0;
	logic [4:0] OPCODE = 5'h00;
	logic [7:0] IO_ADDR = 8'h00;
	logic [15:0] ACC_IN = 16'h0000;
	logic [15:0] INDEX_IN = 16'h0000;
	logic IRQ_REQ = 1'h0;
	logic INT_INHIBIT = 1'h0;
	logic BUSY, DONE, DONE_ADVANCE, INT_ACK, WB_VALID, WB_TO_INDEX;
	logic [15:0] WB_DATA, IO_DATA_IN, IO_DATA_OUT, last_out;
	logic [4:0] IO_DEV_ADDR;
	logic [2:0] IO_FUNC;
	logic IO_SENSE, IO_SENSE_RESP, IO_IN_STROBE, IO_NARROW, IO_OUT_STROBE;
	logic [3:0] false_n = 4'h0;
	logic [15:0] rd_word = 16'h0000;
	logic narrow = 1'h0;
	logic [7:0] last_byte;
	int sense_cnt, in_cnt, out_cnt;
	int errors = 0;
	int checks_done = 0;
	int tno = 0;
	int seed = 84438;
	int i;

	pwb_io_exec i_pwb_io_exec (.REF_CLK(REF_CLK), .RESET(RESET), .START(START),
		.OPCODE(OPCODE), .IO_ADDR(IO_ADDR), .ACC_IN(ACC_IN), .INDEX_IN(INDEX_IN),
		.IRQ_REQ(IRQ_REQ), .INT_INHIBIT(INT_INHIBIT), .BUSY(BUSY), .DONE(DONE),
		.DONE_ADVANCE(DONE_ADVANCE), .INT_ACK(INT_ACK), .WB_VALID(WB_VALID),
		.WB_TO_INDEX(WB_TO_INDEX), .WB_DATA(WB_DATA), .IO_DEV_ADDR(IO_DEV_ADDR),
		.IO_FUNC(IO_FUNC), .IO_SENSE(IO_SENSE), .IO_SENSE_RESP(IO_SENSE_RESP),
		.IO_IN_STROBE(IO_IN_STROBE), .IO_DATA_IN(IO_DATA_IN), .IO_NARROW(IO_NARROW),
		.IO_OUT_STROBE(IO_OUT_STROBE), .IO_DATA_OUT(IO_DATA_OUT));

	pwb_periph_model i_pwb_periph_model (.clk(REF_CLK), .rst(RESET), .false_n(false_n),
		.rd_word(rd_word), .narrow(narrow), .io_sense(IO_SENSE),
		.sense_resp(IO_SENSE_RESP), .in_strobe(IO_IN_STROBE), .data_in(IO_DATA_IN),
		.narrow_o(IO_NARROW), .out_strobe(IO_OUT_STROBE), .data_out(IO_DATA_OUT),
		.sense_cnt(sense_cnt), .in_cnt(in_cnt), .out_cnt(out_cnt),
		.last_out(last_out), .last_byte(last_byte));

	// clock, 25 ns period
	initial begin
		forever #12.5 REF_CLK = ~REF_CLK;
	end

	// compare and count
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	// final counts and verdict
	task automatic test_done();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// position of an input opcode in its group of four: bit1 index, bit0 masked
	function automatic int kin(input int op);
		return (op - (op < 5 ? 1 : (op < 12 ? 8 : 15))) & 3;
	endfunction

	// expected write-back value of an input opcode
	function automatic logic [15:0] exp_wb(input int op, input logic [15:0] a, x, bus,
		input logic nar);
		logic [15:0] r;
		logic [15:0] b;
		r = kin(op) & 2 ? x : a;
		if (op >= 15) begin
			b = {r[15:8], (kin(op) & 1) ? bus[7:0] & r[7:0] : bus[7:0]};
		end else begin
			b = nar ? {8'h00, bus[7:0]} : bus;
			if (kin(op) & 1) b = b & r;
		end
		return b;
	endfunction

	// expected output word: source a, x or zero
	function automatic logic [15:0] exp_out(input int op, input logic [15:0] a, x);
		int k;
		k = op < 8 ? op - 5 : op - 12;
		return k == 2 ? 16'h0000 : (k == 1 ? x : a);
	endfunction

	// issue one instruction, wait for its end and check everything seen
	task automatic run_op(input int op, input logic [7:0] ad, input logic [15:0] a, x, d,
		input logic [3:0] nf, input logic irq, inh, nar);
		int n, s0, i0, o0, lat;
		bit legal, cond, inp, outp, abort;
		logic busy1;
		legal = op >= 1 && op <= 22;
		cond = legal && ((op >= 8 && op <= 14) || op >= 19);
		inp = legal && (op <= 4 || (op >= 8 && op <= 11) || op >= 15);
		outp = legal && !inp;
		abort = cond && irq && !inh && nf != 0;
		lat = !legal ? 1 : (!cond || abort ? 2 : 3 + nf);
		s0 = sense_cnt;
		i0 = in_cnt;
		o0 = out_cnt;
		@(posedge REF_CLK);
		START <= 1'h1;
		OPCODE <= op[4:0];
		IO_ADDR <= ad;
		ACC_IN <= a;
		INDEX_IN <= x;
		IRQ_REQ <= irq;
		INT_INHIBIT <= inh;
		rd_word <= d;
		false_n <= nf;
		narrow <= nar;
		n = 0;
		do begin
			@(posedge REF_CLK);
			START <= 1'h0;
			#1;
			n++;
			if (n == 1) busy1 = BUSY;
		end while (DONE !== 1'h1 && n < 40);
		if (DONE !== 1'h1) begin
			errors++;
			test_done();
		end
		chk("latency", n, lat);
		chk("busy", busy1, legal);
		chk("busy_end", BUSY, 1'h0);
		chk("advance", DONE_ADVANCE, !abort);
		chk("int_ack", INT_ACK, abort);
		chk("wb_valid", WB_VALID, inp && !abort);
		if (inp && !abort) begin
			chk("wb_data", WB_DATA, exp_wb(op, a, x, d, nar));
			chk("wb_to_index", WB_TO_INDEX, (kin(op) & 2) != 0);
		end
		chk("senses", sense_cnt - s0, !cond ? 0 : (abort ? 1 : nf + 1));
		chk("in_strobes", in_cnt - i0, inp && !abort);
		chk("out_strobes", out_cnt - o0, outp && !abort);
		if (outp && !abort) begin
			chk("out_data", last_out, exp_out(op, a, x));
			chk("out_byte", last_byte, exp_out(op, a, x) & 16'h00FF);
		end
		if (legal) begin
			chk("dev_addr", IO_DEV_ADDR, ad[7:3]);
			chk("func", IO_FUNC, ad[2:0]);
		end
		tno++;
		$display("test %0d op %0d done", tno, op);
	endtask

	// reset, every opcode in turn, hand-picked corners, then random traffic
	initial begin
		repeat (6) @(posedge REF_CLK);
		RESET <= 1'h0;
		for (i = 0; i < 32; i++) begin
			run_op(i, 8'($random(seed)), 16'($random(seed)), 16'($random(seed)),
				16'($random(seed)), 4'(i % 3), i % 4 == 3, i % 8 == 7, i % 5 == 1);
		end
		run_op(1, 8'hFF, 16'h1234, 16'h5678, 16'hABCD, 4'h0, 1'h0, 1'h0, 1'h1);
		run_op(18, 8'h00, 16'h0000, 16'hC3FF, 16'hFFA5, 4'h0, 1'h0, 1'h0, 1'h0);
		run_op(12, 8'hA7, 16'hFFFF, 16'h0001, 16'h0000, 4'h3, 1'h1, 1'h1, 1'h0);
		run_op(14, 8'h5A, 16'hFFFF, 16'hFFFF, 16'h0000, 4'h2, 1'h0, 1'h0, 1'h1);
		run_op(22, 8'h81, 16'hFFFF, 16'h00F0, 16'h3C3C, 4'h7, 1'h0, 1'h0, 1'h0);
		for (i = 0; i < 150; i++) begin
			run_op($random(seed) & 31, 8'($random(seed)), 16'($random(seed)),
				16'($random(seed)), 16'($random(seed)), 4'($random(seed) & 3),
				($random(seed) & 3) == 0, 1'($random(seed)), 1'($random(seed)));
		end
		test_done();
	end
endmodule
